// file: logic/rtc_alarm_pkg.sv
// constants for the alarm, flag and control block
package rtc_alarm_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_MONTH    = 5'h05;
  localparam logic [4:0] OFS_ALM_SEC  = 5'h08;
  localparam logic [4:0] OFS_ALM_MIN  = 5'h09;
  localparam logic [4:0] OFS_ALM_HOUR = 5'h0A;
  localparam logic [4:0] OFS_ALM_DAY  = 5'h0B;
  localparam logic [4:0] OFS_WDOG_LO  = 5'h0C;
  localparam logic [4:0] OFS_WDOG_HI  = 5'h0D;
  localparam logic [4:0] OFS_FLAGS    = 5'h0E;
  localparam logic [4:0] OFS_CTRL_B   = 5'h0F;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MASK_BIT      = 7;
  localparam int WEEKDAY_BIT   = 6;
  localparam int OSC_STOP_BIT  = 7;
  localparam int FOUT_DIS_BIT  = 6;
  localparam int BKP_FOUT_BIT  = 5;
  localparam int MAIN_LOW_BIT  = 7;
  localparam int AUX_LOW_BIT   = 6;
  localparam int PF_KEEP_BIT   = 5;
  localparam int PWR_REL_BIT   = 4;
  localparam int ALARM_F_BIT   = 3;
  localparam int KICK_F_BIT    = 2;
  localparam int DOG_F_BIT     = 1;
  localparam int IRQ_P_BIT     = 0;
  localparam int WAKE_EN_BIT   = 4;
  localparam int ALM_IE_BIT    = 3;
  localparam int KICK_IE_BIT   = 2;
  localparam int DOG_EN_BIT    = 1;
  localparam int DOG_STEER_BIT = 0;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_B_RST    = 8'h00;
  localparam logic [7:0] FLAGS_RST     = 8'h10;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam int         ADDR_STABLE_NS = 15;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         ADDR_STABLE_CYC =
    (ADDR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RATE_SECOND = 3'b000,
    RATE_SEC    = 3'b001,
    RATE_MIN    = 3'b010,
    RATE_HOUR   = 3'b011,
    RATE_DAY    = 3'b100
  } rate_type;
endpackage : rtc_alarm_pkg

// file: logic/alarm_match.sv
// alarm comparison against the running time
`timescale 1ns/100ps
module alarm_match
  import rtc_alarm_pkg::*;
(
  // alarm registers
  input  wire logic [7:0] alm_sec_i,
  input  wire logic [7:0] alm_min_i,
  input  wire logic [7:0] alm_hour_i,
  input  wire logic [7:0] alm_day_i,
  // running time
  input  wire logic [6:0] tm_sec_i,
  input  wire logic [6:0] tm_min_i,
  input  wire logic [5:0] tm_hour_i,
  input  wire logic [2:0] tm_weekday_i,
  input  wire logic [5:0] tm_date_i,
  // result
  output wire logic       match_o
);
  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire logic [3:0] masks;
  wire logic       sec_eq;
  wire logic       min_eq;
  wire logic       hour_eq;
  wire logic       dd_eq;
  rate_type        rate;

  assign masks = {alm_day_i[MASK_BIT], alm_hour_i[MASK_BIT],
                  alm_min_i[MASK_BIT], alm_sec_i[MASK_BIT]};
  assign sec_eq  = (alm_sec_i[6:0] == tm_sec_i);
  assign min_eq  = (alm_min_i[6:0] == tm_min_i);
  assign hour_eq = (alm_hour_i[5:0] == tm_hour_i);
  assign dd_eq   = alm_day_i[WEEKDAY_BIT] ?
                   (alm_day_i[5:0] == {3'h0, tm_weekday_i}) :
                   (alm_day_i[5:0] == tm_date_i);

  always_comb begin
    case (masks)
      4'hE:    rate = RATE_SEC;
      4'hC:    rate = RATE_MIN;
      4'h8:    rate = RATE_HOUR;
      4'h0:    rate = RATE_DAY;
      default: rate = RATE_SECOND;
    endcase
  end

  assign match_o = (rate == RATE_SECOND) ||
                   ((rate == RATE_SEC)  && sec_eq) ||
                   ((rate == RATE_MIN)  && sec_eq && min_eq) ||
                   ((rate == RATE_HOUR) && sec_eq && min_eq && hour_eq) ||
                   ((rate == RATE_DAY)  && sec_eq && min_eq && hour_eq && dd_eq);
endmodule : alarm_match

// file: logic/rtc_alarm_flag_control.sv
// alarm, flag and power-request control of the clock device
// Notes on behaviour
// - four mask bits pick once per second, seconds, minutes, hours or day matching.
// - undefined mask patterns fall back to once per second.
// - time matching the unmasked alarm fields sets the alarm flag.
// - weekday select picks day-of-week match when 1, date when 0.
// - each alarm register holds its mask bit in bit 7.
// - oscillator-stop bit runs oscillator at 0; power-on reset clears it.
// - frequency output drives when disable bit is 0 and oscillator runs.
// - backup output bit keeps frequency output in backup if aux supply present.
// - two read-only battery-low flags, main in bit 7, aux in bit 6.
// - on power-fail the power pin floats unless the keep bit is 1.
// - release bit 0 drives power pin low; alarm-wake or kick clears it.
// - alarm flag plus enable raises interrupt; cleared by read or write 0.
// - kick flag set by event or write 1; cleared by read or write 0.
// - watchdog timeout sets dog flag; software writes 0 to clear it.
// - interrupt pending is the OR of three flag-and-enable pairs.
// - interrupt pin low while interrupt pending is 1.
// - alarm flag reaches the interrupt pin only with its enable.
// - alarm flag reaches the power pin only with wake enable.
// - reading the flag register clears alarm, dog, kick and pending flags.
// - flags clear on address change or strobe rise after stable read.
// - power-up clears enables, steering, oscillator-stop and output-disable.
`timescale 1ns/100ps
module rtc_alarm_flag_control
  import rtc_alarm_pkg::*;
#(
  // read-clear timing
  parameter int STABLE_CYC = ADDR_STABLE_CYC
)
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // byte-wide host bus
  input  wire logic [4:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       cs_n_i,
  input  wire logic       oe_n_i,
  input  wire logic       we_n_i,
  output logic      [7:0] rdata_o,
  output logic            rdata_oe_o,
  // running time and update tick
  input  wire logic       sec_tick_i,
  input  wire logic [6:0] tm_sec_i,
  input  wire logic [6:0] tm_min_i,
  input  wire logic [5:0] tm_hour_i,
  input  wire logic [2:0] tm_weekday_i,
  input  wire logic [5:0] tm_date_i,
  input  wire logic [5:0] tm_month_i,
  // events and supply state
  input  wire logic       kick_event_i,
  input  wire logic       dog_timeout_i,
  input  wire logic       main_batt_low_i,
  input  wire logic       aux_batt_low_i,
  input  wire logic       power_fail_i,
  input  wire logic       aux_batt_supply_i,
  input  wire logic       osc_clk_i,
  // pins
  output logic            irq_n_o,
  output logic            irq_n_oe_o,
  output logic            power_req_n_o,
  output logic            power_req_n_oe_o,
  output logic            freq_out_pin_o,
  output logic            osc_run_o,
  // watchdog setup
  output logic      [7:0] dog_lo_o,
  output logic      [7:0] dog_hi_o,
  output logic            dog_steer_o
);
  import rtc_alarm_pkg::*;
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (STABLE_CYC < 1 || STABLE_CYC > 4) begin : g_bad_stable
    $error("stable cycle count outside 1 to 4");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [1:0] STABLE_LAST = 2'(STABLE_CYC - 1);
  logic [7:0] alm_sec_r, alm_min_r, alm_hour_r, alm_day_r;
  logic [7:0] dog_lo_r, dog_hi_r;
  logic [2:0] month_ctl_r;
  logic [7:0] ctrl_b_r;
  logic       pf_keep_r, pwr_rel_r;
  logic       alarm_flag_r, kick_flag_r, dog_flag_r;
  logic       clr_armed_r;
  logic [4:0] addr_prev_r;
  logic [1:0] stable_cnt_r;
  logic       cs_prev_r, oe_prev_r, we_prev_r;
  logic [7:0] rdata_r;
  logic       alarm_flag_nxt, kick_flag_nxt, dog_flag_nxt, pwr_rel_nxt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic       match;
  wire logic       rd_act;
  wire logic       wr_strobe;
  wire logic       wr_flags;
  wire logic       flag_read;
  wire logic       read_done;
  wire logic       irq_pending;
  wire logic       alarm_set;
  wire logic [7:0] flags_view;
  wire logic [7:0] rd_mux;
  wire logic       wr_month;
  wire logic       wr_alm_sec;
  wire logic       wr_alm_min;
  wire logic       wr_alm_hour;
  wire logic       wr_alm_day;
  wire logic       wr_dog_lo;
  wire logic       wr_dog_hi;
  wire logic       wr_ctrl_b;

  alarm_match u_match (
    .alm_sec_i    (alm_sec_r),
    .alm_min_i    (alm_min_r),
    .alm_hour_i   (alm_hour_r),
    .alm_day_i    (alm_day_r),
    .tm_sec_i     (tm_sec_i),
    .tm_min_i     (tm_min_i),
    .tm_hour_i    (tm_hour_i),
    .tm_weekday_i (tm_weekday_i),
    .tm_date_i    (tm_date_i),
    .match_o      (match)
  );

  assign rd_act    = !cs_n_i && !oe_n_i;
  // write taken on falling edge of write strobe while selected
  assign wr_strobe = !cs_n_i && !we_n_i && we_prev_r;
  assign wr_flags  = wr_strobe && (addr_i == OFS_FLAGS);
  assign flag_read = rd_act && (addr_i == OFS_FLAGS) &&
                     (addr_i == addr_prev_r);
  assign read_done = clr_armed_r &&
                     ((addr_i != addr_prev_r) || (oe_n_i && !oe_prev_r) ||
                      (cs_n_i && !cs_prev_r));
  assign alarm_set = sec_tick_i && match;
  assign irq_pending = (alarm_flag_r && ctrl_b_r[ALM_IE_BIT]) ||
                       (kick_flag_r && ctrl_b_r[KICK_IE_BIT]) ||
                       (dog_flag_r && ctrl_b_r[DOG_EN_BIT]);
  assign flags_view = {main_batt_low_i, aux_batt_low_i, pf_keep_r, pwr_rel_r,
                       alarm_flag_r, kick_flag_r, dog_flag_r, irq_pending};

  assign rd_mux = (addr_i == OFS_MONTH)    ? {month_ctl_r, 5'h00} | {3'h0, tm_month_i[4:0]} :
                  (addr_i == OFS_ALM_SEC)  ? alm_sec_r :
                  (addr_i == OFS_ALM_MIN)  ? alm_min_r :
                  (addr_i == OFS_ALM_HOUR) ? alm_hour_r :
                  (addr_i == OFS_ALM_DAY)  ? alm_day_r :
                  (addr_i == OFS_WDOG_LO)  ? dog_lo_r :
                  (addr_i == OFS_WDOG_HI)  ? dog_hi_r :
                  (addr_i == OFS_FLAGS)    ? flags_view :
                  (addr_i == OFS_CTRL_B)   ? ctrl_b_r : ZERO_BYTE;

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  assign wr_month    = wr_strobe && (addr_i == OFS_MONTH);
  assign wr_alm_sec  = wr_strobe && (addr_i == OFS_ALM_SEC);
  assign wr_alm_min  = wr_strobe && (addr_i == OFS_ALM_MIN);
  assign wr_alm_hour = wr_strobe && (addr_i == OFS_ALM_HOUR);
  assign wr_alm_day  = wr_strobe && (addr_i == OFS_ALM_DAY);
  assign wr_dog_lo   = wr_strobe && (addr_i == OFS_WDOG_LO);
  assign wr_dog_hi   = wr_strobe && (addr_i == OFS_WDOG_HI);
  assign wr_ctrl_b   = wr_strobe && (addr_i == OFS_CTRL_B);

  // ----------------------------------------------------------------
  // flag next values, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    alarm_flag_nxt = alarm_flag_r;
    kick_flag_nxt  = kick_flag_r;
    dog_flag_nxt   = dog_flag_r;
    pwr_rel_nxt    = pwr_rel_r;
    if (read_done) begin
      alarm_flag_nxt = 1'b0;
      kick_flag_nxt  = 1'b0;
      dog_flag_nxt   = 1'b0;
    end
    if (wr_flags) begin
      alarm_flag_nxt = wdata_i[ALARM_F_BIT] & alarm_flag_nxt;
      kick_flag_nxt  = wdata_i[KICK_F_BIT];
      dog_flag_nxt   = wdata_i[DOG_F_BIT] & dog_flag_nxt;
      pwr_rel_nxt    = wdata_i[PWR_REL_BIT];
    end
    if (alarm_set) begin
      alarm_flag_nxt = 1'b1;
    end
    if (kick_event_i) begin
      kick_flag_nxt = 1'b1;
    end
    if (dog_timeout_i) begin
      dog_flag_nxt = 1'b1;
    end
    if ((alarm_flag_nxt && ctrl_b_r[WAKE_EN_BIT]) || kick_flag_nxt) begin
      pwr_rel_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      month_ctl_r  <= 3'h0;
      ctrl_b_r     <= CTRL_B_RST;
      pf_keep_r    <= 1'b0;
      pwr_rel_r    <= FLAGS_RST[PWR_REL_BIT];
      alarm_flag_r <= 1'b0;
      kick_flag_r  <= 1'b0;
      dog_flag_r   <= 1'b0;
      alm_sec_r    <= ZERO_BYTE;
      alm_min_r    <= ZERO_BYTE;
      alm_hour_r   <= ZERO_BYTE;
      alm_day_r    <= ZERO_BYTE;
      dog_lo_r     <= ZERO_BYTE;
      dog_hi_r     <= ZERO_BYTE;
    end else begin
      alarm_flag_r <= alarm_flag_nxt;
      kick_flag_r  <= kick_flag_nxt;
      dog_flag_r   <= dog_flag_nxt;
      pwr_rel_r    <= pwr_rel_nxt;
      if (wr_flags) begin
        pf_keep_r <= wdata_i[PF_KEEP_BIT];
      end
      if (wr_month) begin
        month_ctl_r <= wdata_i[7:5];
      end
      if (wr_alm_sec) begin
        alm_sec_r <= wdata_i;
      end
      if (wr_alm_min) begin
        alm_min_r <= wdata_i;
      end
      if (wr_alm_hour) begin
        alm_hour_r <= wdata_i;
      end
      if (wr_alm_day) begin
        alm_day_r <= wdata_i;
      end
      if (wr_dog_lo) begin
        dog_lo_r <= wdata_i;
      end
      if (wr_dog_hi) begin
        dog_hi_r <= wdata_i;
      end
      if (wr_ctrl_b) begin
        ctrl_b_r <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // read tracking for clear-on-read
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_prev_r  <= 5'h00;
      stable_cnt_r <= 2'h0;
      clr_armed_r  <= 1'b0;
      cs_prev_r    <= 1'b1;
      oe_prev_r    <= 1'b1;
      we_prev_r    <= 1'b1;
      rdata_r      <= ZERO_BYTE;
    end else begin
      addr_prev_r <= addr_i;
      cs_prev_r   <= cs_n_i;
      oe_prev_r   <= oe_n_i;
      we_prev_r   <= we_n_i;
      rdata_r     <= rd_mux;
      if (read_done) begin
        clr_armed_r  <= 1'b0;
        stable_cnt_r <= 2'h0;
      end else if (flag_read) begin
        if (stable_cnt_r >= STABLE_LAST) begin
          clr_armed_r <= 1'b1;
        end else begin
          stable_cnt_r <= stable_cnt_r + 2'h1;
        end
      end else if (!clr_armed_r) begin
        stable_cnt_r <= 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign rdata_o          = rdata_r;
  assign rdata_oe_o       = rd_act;
  assign irq_n_o          = 1'b0;
  assign irq_n_oe_o       = irq_pending;
  assign power_req_n_o    = 1'b0;
  assign power_req_n_oe_o = !pwr_rel_r && (!power_fail_i || pf_keep_r);
  assign osc_run_o        = !month_ctl_r[2];
  assign freq_out_pin_o   = osc_clk_i && osc_run_o &&
                            (power_fail_i ? (month_ctl_r[0] && aux_batt_supply_i)
                                          : !month_ctl_r[1]);
  assign dog_lo_o         = dog_lo_r;
  assign dog_hi_o         = dog_hi_r;
  assign dog_steer_o      = ctrl_b_r[DOG_STEER_BIT];
endmodule : rtc_alarm_flag_control

// file: verif/rtc_alarm_flag_control_checker.sv
// port assertions for the alarm, flag and power-request block
`timescale 1ns/100ps
module rtc_alarm_flag_control_checker
  import rtc_alarm_pkg::*;
(
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  // host bus
  input wire logic [4:0] addr_i,
  input wire logic       cs_n_i,
  input wire logic       oe_n_i,
  input wire logic       we_n_i,
  input wire logic [7:0] rdata_o,
  // events and supply
  input wire logic       sec_tick_i,
  input wire logic       kick_event_i,
  input wire logic       dog_timeout_i,
  input wire logic       main_batt_low_i,
  input wire logic       aux_batt_low_i,
  input wire logic       power_fail_i,
  // pins
  input wire logic       irq_n_oe_o,
  input wire logic       power_req_n_oe_o,
  input wire logic       freq_out_pin_o,
  input wire logic       osc_run_o,
  input wire logic       dog_steer_o
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_armed;
    (addr_i == OFS_FLAGS && !cs_n_i && !oe_n_i) [*3] ##1 oe_n_i;
  endsequence
  property p_clear; s_armed |-> ##[1:2] !irq_n_oe_o; endproperty
  property p_batt;
    $past(addr_i) == OFS_FLAGS |-> rdata_o[7:6] == {$past(main_batt_low_i), $past(aux_batt_low_i)};
  endproperty
  property p_irq_pin; $past(addr_i) == OFS_FLAGS |-> rdata_o[IRQ_P_BIT] == $past(irq_n_oe_o);
  endproperty
  property p_irq_src; $past(addr_i) == OFS_FLAGS && rdata_o[IRQ_P_BIT] |-> |rdata_o[3:1];
  endproperty
  property p_pwr;
    $past(addr_i) == OFS_FLAGS |-> $past(power_req_n_oe_o) ==
      (!rdata_o[PWR_REL_BIT] && (!$past(power_fail_i) || rdata_o[PF_KEEP_BIT]));
  endproperty
  property p_kick_rel; $past(addr_i) == OFS_FLAGS && rdata_o[KICK_F_BIT] |-> !rdata_o[PWR_REL_BIT];
  endproperty
  property p_osc; $past(addr_i) == OFS_MONTH |-> rdata_o[OSC_STOP_BIT] == !$past(osc_run_o);
  endproperty
  property p_freq; !osc_run_o [*2] |-> $stable(freq_out_pin_o); endproperty
  property p_rst;
    $fell(rst_i) |-> osc_run_o && !irq_n_oe_o && !dog_steer_o && !power_req_n_oe_o;
  endproperty
  property p_rise;
    $rose(irq_n_oe_o) |-> $past(sec_tick_i) || $past(kick_event_i) || $past(dog_timeout_i) ||
      !($past(we_n_i) || $past(cs_n_i));
  endproperty
  a_clear: assert property (p_clear) else $error("flag read did not release irq");
  a_batt: assert property (p_batt) else $error("battery flags wrong");
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin and pending differ");
  a_irq_src: assert property (p_irq_src) else $error("pending without flag");
  a_pwr: assert property (p_pwr) else $error("power pin wrong");
  a_kick_rel: assert property (p_kick_rel) else $error("kick left power released");
  a_osc: assert property (p_osc) else $error("osc run wrong");
  a_freq: assert property (p_freq) else $error("output moves while osc stopped");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  c_clear: cover property (s_armed);
  c_irq: cover property ($rose(irq_n_oe_o));
  c_pf: cover property (power_fail_i && power_req_n_oe_o);
endmodule : rtc_alarm_flag_control_checker

bind rtc_alarm_flag_control rtc_alarm_flag_control_checker u_rtc_alarm_flag_control_checker (.*);

// file: verif/host_bus_model.sv
// host processor model on the byte-wide register bus
`timescale 1ns/100ps
module host_bus_model
  import rtc_alarm_pkg::*;
(
  // clock and read data
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  // bus drive
  output logic      [4:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            cs_n_o,
  output logic            oe_n_o,
  output logic            we_n_o
);
  initial begin
    addr_o = 5'h00;
    wdata_o = 8'h00;
    {cs_n_o, oe_n_o, we_n_o} = 3'h7;
  end
  // write taken at one edge, strobes then lifted
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    {cs_n_o, we_n_o} = 2'h0;
    @(posedge core_clk_i);
    #1;
    {cs_n_o, we_n_o} = 2'h3;
    wdata_o = ~d;
  endtask : wr
  // address held three edges so a flag read counts as stable
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    {cs_n_o, oe_n_o} = 2'h0;
    @(posedge core_clk_i);
    #1;
    d = rdata_i;
    repeat (2) @(posedge core_clk_i);
    #1;
    {cs_n_o, oe_n_o} = 2'h3;
  endtask : rd
endmodule : host_bus_model

// file: verif/test_rtc_alarm_flag_control.sv
// self-checking bench for the alarm, flag and power-request block
`timescale 1ns/100ps
module test_rtc_alarm_flag_control;
  import rtc_alarm_pkg::*;
  logic       core_clk_i, rst_i, cs_n_i, oe_n_i, we_n_i, rdata_oe_o, sec_tick_i;
  logic       kick_event_i, dog_timeout_i, main_batt_low_i, aux_batt_low_i, power_fail_i;
  logic       aux_batt_supply_i, osc_clk_i, irq_n_o, irq_n_oe_o, power_req_n_o;
  logic       power_req_n_oe_o, freq_out_pin_o, osc_run_o, dog_steer_o, wsel, e;
  logic [4:0] addr_i;
  logic [7:0] wdata_i, rdata_o, dog_lo_o, dog_hi_o, rd_v;
  logic [6:0] tm_sec_i, tm_min_i, as, am;
  logic [5:0] tm_hour_i, tm_date_i, tm_month_i, ah, ad;
  logic [2:0] tm_weekday_i;
  logic [3:0] m, off;
  logic [1:0] en;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  // ----------------------------------------------------------------
  // design, host and helpers
  // ----------------------------------------------------------------
  rtc_alarm_flag_control u_rtc_alarm_flag_control (.*);
  host_bus_model u_host_bus_model (.core_clk_i(core_clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
    .wdata_o(wdata_i), .cs_n_o(cs_n_i), .oe_n_o(oe_n_i), .we_n_o(we_n_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    osc_clk_i <= rst_i ? 1'b0 : !osc_clk_i;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host_bus_model.wr(a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    u_host_bus_model.rd(a, rd_v);
  endtask : rd
  task automatic pulse(ref logic s);
    @(posedge core_clk_i);
    #1;
    s = 1'b1;
    @(posedge core_clk_i);
    #1;
    s = 1'b0;
  endtask : pulse
  function automatic logic [7:0] fl(input logic k, r, a, q, d, i);
    return {main_batt_low_i, aux_batt_low_i, k, r, a, q, d, i};
  endfunction : fl
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    {sec_tick_i, kick_event_i, dog_timeout_i, main_batt_low_i, aux_batt_low_i} = 5'h00;
    {power_fail_i, aux_batt_supply_i} = 2'h0;
    {tm_sec_i, tm_min_i, tm_hour_i, tm_weekday_i, tm_date_i, tm_month_i} = '0;
    void'($urandom(32'h75E0));
    repeat (8) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    rd(OFS_FLAGS);
    check(rd_v, fl(0, 1, 0, 0, 0, 0));
    rd(OFS_CTRL_B);
    check(rd_v, CTRL_B_RST);
    rd(OFS_MONTH);
    check(rd_v & 8'hC0, 8'h00);
    for (int i = 0; i < 24; i++) begin
      m = (i < 5) ? 4'(20'h08CEF >> (4 * i)) : 4'($urandom);
      {en, wsel, main_batt_low_i, aux_batt_low_i} = 5'($urandom);
      {tm_sec_i, tm_min_i} = {7'($urandom % 60), 7'($urandom % 60)};
      {tm_hour_i, tm_weekday_i} = {6'($urandom % 24), 3'(1 + $urandom % 7)};
      {tm_date_i, tm_month_i} = {6'(1 + $urandom % 31), 6'($urandom % 13)};
      off = ($urandom % 2) ? 4'h0 : 4'(1 << ($urandom % 4));
      as = tm_sec_i + 7'(off[0]);
      am = tm_min_i + 7'(off[1]);
      ah = tm_hour_i + 6'(off[2]);
      ad = (wsel ? {3'h0, tm_weekday_i} : tm_date_i) + 6'(off[3]);
      case (m)
        4'hE: e = !off[0];
        4'hC: e = !(|off[1:0]);
        4'h8: e = !(|off[2:0]);
        4'h0: e = !(|off);
        default: e = 1'b1;
      endcase
      wr(OFS_CTRL_B, {3'h0, en, 3'h0});
      wr(OFS_ALM_SEC, {m[0], as});
      wr(OFS_ALM_MIN, {m[1], am});
      wr(OFS_ALM_HOUR, {m[2], 1'b0, ah});
      wr(OFS_ALM_DAY, {m[3], wsel, ad});
      wr(OFS_FLAGS, FLAGS_RST);
      rd(OFS_ALM_DAY);
      check(rd_v, {m[3], wsel, ad});
      rd(OFS_FLAGS);
      check(rd_v, fl(0, 1, 0, 0, 0, 0));
      pulse(sec_tick_i);
      rd(OFS_FLAGS);
      check(rd_v, fl(0, !(e && en[1]), e, 0, 0, e && en[0]));
      rd(OFS_FLAGS);
      check(rd_v, fl(0, !(e && en[1]), 0, 0, 0, 0));
    end
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL_B, 8'h06);
      wr(OFS_FLAGS, FLAGS_RST);
      if (k == 0) pulse(kick_event_i);
      else pulse(dog_timeout_i);
      rd(OFS_FLAGS);
      check(rd_v, fl(0, 1'(k), 0, 1'(!k), 1'(k), 1));
      rd(OFS_FLAGS);
      check(rd_v, fl(0, 1'(k), 0, 0, 0, 0));
      if (k == 0) wr(OFS_FLAGS, 8'h14);
      else pulse(dog_timeout_i);
      if (k == 1) wr(OFS_FLAGS, FLAGS_RST);
      rd(OFS_FLAGS);
      check(rd_v & 8'h0F, k ? 8'h00 : 8'h05);
    end
    power_fail_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr(OFS_FLAGS, p ? 8'h00 : 8'h20);
      rd(OFS_FLAGS);
      check(rd_v, fl(1'(!p), 0, 0, 0, 0, 0));
      check({7'h00, power_req_n_oe_o}, 8'(!p));
    end
    wr(OFS_MONTH, 8'h20);
    aux_batt_supply_i = 1'b1;
    for (int q = 0; q < 4; q++) begin
      repeat (2) begin
        @(posedge core_clk_i);
        #1;
        check({7'h00, freq_out_pin_o}, {7'h00, osc_clk_i && !q[0]});
      end
      if (q == 1) power_fail_i = 1'b0;
      else wr(OFS_MONTH, (q == 2) ? 8'h40 : 8'h00);
    end
    wr(OFS_MONTH, 8'h80);
    check({6'h00, osc_run_o, freq_out_pin_o}, 8'h00);
    wr(5'h15, 8'hFF);
    rd(5'h15);
    check(rd_v, ZERO_BYTE);
    rd_v = 8'($urandom);
    wr(OFS_WDOG_LO, rd_v);
    wr(OFS_WDOG_HI, ~rd_v);
    wr(OFS_CTRL_B, 8'h01);
    check(dog_lo_o, rd_v);
    check(dog_hi_o, ~rd_v);
    check({4'h0, dog_steer_o, irq_n_o, power_req_n_o, rdata_oe_o}, 8'h08);
    repeat (4) @(posedge core_clk_i);
    end_sim();
  end
endmodule : test_rtc_alarm_flag_control
